// *** dv/fabm_monitor_sva.sv ***
/* fabm_monitor_sva: port-level checks of the background ambient monitor.
   assumes hready is tied to hreadyout and only word transfers occur. */
`timescale 1ns/1ps
module fabm_monitor_sva (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [31:0]            hrdata,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire fabm_pkg::fabm_sample_s sample,
  input wire logic                   ext_irq,
  input wire logic                   irq,
  input wire logic                   general_output_pin
);
  import fabm_pkg::*;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr, rd, ev;
  assign wr = hsel && hready && htrans[1] && hwrite;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  assign ev = sample.valid && sample.float_led && sample.subtract;
  // a rise needs a subtract sample three cycles back or a register write three or four cycles back
  sequence s_cause; $past(ev, 3) || $past(wr, 3) || $past(wr, 4); endsequence
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("error response");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd)) else $error("hrdata moved");
  unmapped_zero_a: assert property (rd && haddr[7:0] >= 8'h50 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  irq_cause_a: assert property ($rose(irq) |-> s_cause) else $error("irq rose unprompted");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr, 3)) else $error("irq dropped unprompted");
  pin_cause_a: assert property ($rose(general_output_pin) |-> s_cause or $past(ext_irq, 3))
    else $error("pin rose unprompted");
  rst_quiet_a: assert property ($rose(hresetn) |-> !irq && !general_output_pin && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
endmodule
bind fabm_monitor fabm_monitor_sva chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hrdata, .hready,
  .hreadyout, .hresp, .sample, .ext_irq, .irq, .general_output_pin);

// *** dv/fabm_seq_model.sv ***
/* fabm_seq_model: sequencer stand-in that issues one converter result.
   assumes requests are at least two cycles apart. */
`timescale 1ns/1ps
module fabm_seq_model (
  input wire logic                   hclk,
  input wire logic                   go,
  input wire logic                   flt,
  input wire logic                   sub,
  input wire logic [1:0]             ch,
  input wire logic [fabm_pkg::ADC_W-1:0] raw,
  output fabm_pkg::fabm_sample_s     sample = '0
);
  import fabm_pkg::*;
  // subtract marks an led-masked pulse
  // idle cycles show inverted data so stale values are never mistaken
  always @(posedge hclk)
    sample <= go ? '{1'b1, flt, sub, ch, raw} : '{1'b0, 1'b0, 1'b0, ~sample.channel, ~sample.raw};
endmodule

// *** dv/tb.sv ***
/* tb: self-checking bench of the background ambient monitor.
   assumes a zero-wait slave and the sequencer model at the sample port. */
`timescale 1ns/1ps
module tb;
  import fabm_pkg::*;
  logic             hclk, hresetn, hsel, hwrite, ext_irq, go, flt, sub, chk, hreadyout, hresp, irq, pin;
  logic [31:0]      haddr, hwdata, hrdata;
  logic [1:0]       htrans, ch;
  logic [ADC_W-1:0] raw;
  fabm_sample_s     sample;
  logic [31:0]      q[$];
  int               n_fail, tests_run;
  int unsigned      t, o;
  fabm_monitor dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sample, .ext_irq, .irq, .general_output_pin(pin));
  fabm_seq_model seq_u (.hclk, .go, .flt, .sub, .ch, .raw, .sample);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= HTRANS_NONSEQ; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    if (!w) begin
      q.push_back(e);
      chk <= 1'b1;
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk <= 1'b0;
  endtask
  // two idle edges after the pulse let the flag settle before a read
  task snd(input logic [1:0] c, input logic [ADC_W-1:0] r, input logic s, input logic f);
    @(posedge hclk);
    go <= 1'b1; ch <= c; raw <= r; sub <= s; flt <= f;
    @(posedge hclk);
    go <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  // ----------------------------------------------------------------
  // processes
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) if (chk) check(hrdata, q.pop_front());
  // the whole run needs about 330 cycles; the 10000-cycle limit allows some thirty times that
  initial begin
    #200us;
    n_fail++;
    results;
  end
  initial begin
    {hsel, hwrite, ext_irq, go, flt, sub, chk} = '0;
    haddr = '0; hwdata = '0; htrans = '0; ch = '0; raw = '0; hresetn = 1'b0;
    void'($urandom(85860));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      xfer(1'b0, OFS_THR0 + 8'(4 * c), 32'h0, {18'h0, THR_RST});
      xfer(1'b0, OFS_COUNT0 + 8'(4 * c), 32'h0, 32'h0);
    end
    xfer(1'b0, 8'h50, 32'h0, 32'h0);
    for (int c = 0; c < 4; c++) begin
      t = $urandom_range(900, 100);
      o = $urandom_range(400, 0);
      xfer(1'b1, OFS_THR0 + 8'(4 * c), t, 32'h0);
      xfer(1'b1, OFS_OFFSET0 + 8'(4 * c), o, 32'h0);
      xfer(1'b1, OFS_LIMIT0 + 8'(4 * c), 32'h1, 32'h0);
      xfer(1'b1, OFS_CTRL, 32'h0, 32'h0);
      snd(2'(c), ADC_W'(t + o + 1), 1'b1, 1'b1);
      xfer(1'b1, OFS_CTRL, 32'h1, 32'h0);
      snd(2'(c), ADC_W'(t + o), 1'b1, 1'b1);
      snd(2'(c), ADC_W'(t + o + 1), 1'b0, 1'b1);
      snd(2'(c), ADC_W'(t + o + 1), 1'b1, 1'b0);
      snd(2'(c), ADC_W'(t + o + 1), 1'b1, 1'b1);
      xfer(1'b0, OFS_COUNT0 + 8'(4 * c), 32'h0, 32'h1);
      xfer(1'b0, OFS_FLAG, 32'h0, 32'((1 << c) - 1));
      snd(2'(c), ADC_W'(t + o + 1), 1'b1, 1'b1);
      xfer(1'b0, OFS_FLAG, 32'h0, 32'((2 << c) - 1));
    end
    // host answers a raised flag by lifting the channel threshold
    xfer(1'b1, OFS_THR0, 32'(THR_RST), 32'h0);
    snd(2'h0, THR_RST, 1'b1, 1'b1);
    xfer(1'b0, OFS_COUNT0, 32'h0, 32'h2);
    for (int p = 0; p < 4; p++) begin
      for (int e = 0; e < 2; e++) begin
        ext_irq <= e[0];
        xfer(1'b1, OFS_PINSEL, 32'(p), 32'h0);
        repeat (3) @(posedge hclk);
        check({31'h0, pin}, {31'h0, p[0] | (p[1] & e[0])});
      end
    end
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, OFS_MASK, 32'hf, 32'h0);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    xfer(1'b1, OFS_FLAG, 32'hf, 32'h0);
    xfer(1'b0, OFS_FLAG, 32'h0, 32'hf);
    xfer(1'b1, OFS_CTRL, 32'h3, 32'h0);
    xfer(1'b0, OFS_CTRL, 32'h0, 32'h1);
    xfer(1'b1, OFS_FLAG, 32'hf, 32'h0);
    xfer(1'b0, OFS_FLAG, 32'h0, 32'h0);
    xfer(1'b0, OFS_COUNT0, 32'h0, 32'h0);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    // a reset in mid-run must drop a live count and the mask
    snd(2'h1, THR_RST, 1'b1, 1'b1);
    xfer(1'b0, OFS_COUNT0 + 8'h04, 32'h0, 32'h1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, OFS_COUNT0 + 8'h04, 32'h0, 32'h0);
    xfer(1'b0, OFS_MASK, 32'h0, 32'h0);
    results;
  end
endmodule

// *** inc/fabm_pkg.sv ***
/*
  fabm_pkg: constants, register map and carrier types of the float-mode
  background ambient monitor.
  assumes an AHB-Lite register bus and a sequencer that presents one
  converter result per pulse with a subtract marker.
*/
package fabm_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH    = 4;
  localparam int unsigned ADC_W     = 14;
  localparam int unsigned CNT_W     = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_FLAG     = 8'h04;
  localparam logic [7:0] OFS_MASK     = 8'h08;
  localparam logic [7:0] OFS_PINSEL   = 8'h0c;
  localparam logic [7:0] OFS_THR0     = 8'h10;
  localparam logic [7:0] OFS_OFFSET0  = 8'h20;
  localparam logic [7:0] OFS_LIMIT0   = 8'h30;
  localparam logic [7:0] OFS_COUNT0   = 8'h40;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_CLRCNT_BIT = 1;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [13:0] THR_RST        = 14'h3fff;
  localparam logic [13:0] OFFSET_RST     = 14'h0000;
  localparam logic [7:0]  LIMIT_RST      = 8'h00;
  localparam logic [3:0]  MASK_RST       = 4'h0;
  localparam logic [1:0]  PINSEL_RST     = 2'h0;

  // output pin combinations
  typedef enum logic [1:0] {
    FABM_PIN_OFF       = 2'h0,
    FABM_PIN_FLAG_ANY  = 2'h1,
    FABM_PIN_IRQ       = 2'h2,
    FABM_PIN_FLAG_OR_IRQ = 2'h3
  } fabm_pinsel_e;

  // one converter result from the sequencer
  typedef struct packed {
    logic              valid;
    logic              float_led;
    logic              subtract;
    logic [1:0]        channel;
    logic [ADC_W-1:0]  raw;
  } fabm_sample_s;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage

// *** logic/fabm_monitor.sv ***
/*
  fabm_monitor: background ambient monitor for float LED mode with an
  AHB-Lite register slave, sticky background flags and an interrupt.
  assumes samples arrive on hclk from the sequencer and that the bus
  master issues only whole-word single transfers.
*/
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module fabm_monitor (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire fabm_pkg::fabm_sample_s sample,
  input  wire logic                 ext_irq,
  output logic                      irq,
  output logic                      general_output_pin
);
  import fabm_pkg::*;

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  // channel registers sit four words to a group, low bits must be zero
  function automatic logic fabm_in_group(input logic [7:0] addr,
                                         input logic [7:0] base);
    fabm_in_group = (addr[7:4] == base[7:4]) && (addr[1:0] == 2'h0);
  endfunction

  // one fixed register, exact byte address
  function automatic logic fabm_is_reg(input logic [7:0] addr,
                                       input logic [7:0] ofs);
    fabm_is_reg = (addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // external interrupt synchroniser
  // ----------------------------------------------------------------
  // other devices run off their own clocks, so retime before use
  logic        ext_sync1_reg;
  logic        ext_sync2_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
    end else begin
      ext_sync1_reg <= ext_irq;
      ext_sync2_reg <= ext_sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // bus address phase capture
  // ----------------------------------------------------------------
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rdata_reg;

  wire         addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  wire         rd_take  = addr_ok && !hwrite;
  wire         wr_take  = addr_ok && hwrite;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]      ctrl_reg;
  logic [NUM_CH-1:0] flag_reg;
  logic [NUM_CH-1:0] mask_reg;
  logic [1:0]       pinsel_reg;
  logic [ADC_W-1:0] thr_reg    [NUM_CH];
  logic [ADC_W-1:0] offset_reg [NUM_CH];
  logic [CNT_W-1:0] limit_reg  [NUM_CH];
  logic [CNT_W-1:0] count_reg  [NUM_CH];

  wire         wr_ctrl   = wr_pend_reg && fabm_is_reg(wr_addr_reg, OFS_CTRL);
  wire         wr_flag   = wr_pend_reg && fabm_is_reg(wr_addr_reg, OFS_FLAG);
  wire         wr_mask   = wr_pend_reg && fabm_is_reg(wr_addr_reg, OFS_MASK);
  wire         wr_pinsel = wr_pend_reg && fabm_is_reg(wr_addr_reg, OFS_PINSEL);
  // misaligned offsets match no group, so such writes are dropped
  wire         wr_thr    = wr_pend_reg && fabm_in_group(wr_addr_reg, OFS_THR0);
  wire         wr_offset = wr_pend_reg && fabm_in_group(wr_addr_reg, OFS_OFFSET0);
  wire         wr_limit  = wr_pend_reg && fabm_in_group(wr_addr_reg, OFS_LIMIT0);
  wire [1:0]   wr_ch     = wr_addr_reg[3:2];
  wire         monitor_en = ctrl_reg[CTRL_EN_BIT];
  wire         clr_counts = wr_ctrl && hwdata[CTRL_CLRCNT_BIT];

  // ----------------------------------------------------------------
  // sample evaluation
  // ----------------------------------------------------------------
  // offset corrected result
  function automatic logic signed [ADC_W:0] fabm_corrected(input logic [ADC_W-1:0] raw,
                                                           input logic [ADC_W-1:0] ofs);
    fabm_corrected = $signed({1'b0, raw}) - $signed({1'b0, ofs});
  endfunction

  wire [1:0]             s_ch   = sample.channel;
  wire [ADC_W-1:0]       s_raw  = sample.raw;
  wire [ADC_W-1:0]       s_ofs  = offset_reg[s_ch];
  wire [ADC_W-1:0]       s_thr  = thr_reg[s_ch];
  // one extra bit keeps a result below the offset from wrapping high
  wire signed [ADC_W:0]  s_corr = fabm_corrected(s_raw, s_ofs);
  wire                   s_eval = monitor_en && sample.valid && sample.float_led && sample.subtract;
  wire                   s_exceed = s_eval && (s_corr > $signed({1'b0, s_thr}));

  // ----------------------------------------------------------------
  // per-channel counters and flags
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] flag_set;
  logic [NUM_CH-1:0] count_inc;
  logic [NUM_CH-1:0] count_full;
  wire  [NUM_CH-1:0] flag_clr = wr_flag ? hwdata[NUM_CH-1:0] : '0;

  for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_ch
    // saturate rather than wrap so a long burst never looks quiet
    assign count_full[gi] = (count_reg[gi] == {CNT_W{1'b1}});
    // increment on an exceedance of this channel
    assign count_inc[gi]  = s_exceed && (s_ch == 2'(gi)) && !count_full[gi];
    assign flag_set[gi]   = (count_reg[gi] > limit_reg[gi]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        count_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (count_inc[i]) begin
          count_reg[i] <= count_reg[i] + 1'b1;
        end else if (clr_counts) begin
          count_reg[i] <= '0;
        end
      end
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_set | (flag_reg & ~flag_clr);
    end
  end

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  // enable gates every evaluation
  // the clear bit is not stored, so it always reads back as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= {31'h0000_0000, hwdata[CTRL_EN_BIT]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= hwdata[NUM_CH-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pinsel_reg <= PINSEL_RST;
    end else if (wr_pinsel) begin
      pinsel_reg <= hwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // channel configuration
  // ----------------------------------------------------------------
  // per-channel background threshold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        thr_reg[i] <= THR_RST;
      end
    end else if (wr_thr) begin
      thr_reg[wr_ch] <= hwdata[ADC_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        offset_reg[i] <= OFFSET_RST;
      end
    end else if (wr_offset) begin
      offset_reg[wr_ch] <= hwdata[ADC_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        limit_reg[i] <= LIMIT_RST;
      end
    end else if (wr_limit) begin
      limit_reg[wr_ch] <= hwdata[CNT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] rd_addr = haddr[7:0];
  wire [1:0] rd_ch   = rd_addr[3:2];
  logic [31:0] rd_value;

  // flags readable by host
  // unmapped or misaligned offsets fall through to zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (fabm_in_group(rd_addr, OFS_THR0)) begin
      rd_value = 32'(thr_reg[rd_ch]);
    end else if (fabm_in_group(rd_addr, OFS_OFFSET0)) begin
      rd_value = 32'(offset_reg[rd_ch]);
    end else if (fabm_in_group(rd_addr, OFS_LIMIT0)) begin
      rd_value = 32'(limit_reg[rd_ch]);
    end else if (fabm_in_group(rd_addr, OFS_COUNT0)) begin
      rd_value = 32'(count_reg[rd_ch]);
    end else if (fabm_is_reg(rd_addr, OFS_CTRL)) begin
      rd_value = ctrl_reg;
    end else if (fabm_is_reg(rd_addr, OFS_FLAG)) begin
      rd_value = 32'(flag_reg);
    end else if (fabm_is_reg(rd_addr, OFS_MASK)) begin
      rd_value = 32'(mask_reg);
    end else if (fabm_is_reg(rd_addr, OFS_PINSEL)) begin
      rd_value = 32'(pinsel_reg);
    end
  end

  // a write is held into its data phase, where hwdata arrives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_take;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_reg <= 8'h00;
    end else if (wr_take) begin
      wr_addr_reg <= haddr[7:0];
    end
  end

  // read data taken at the address phase, so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_reg <= rd_value;
    end
  end

  // ----------------------------------------------------------------
  // bus response
  // ----------------------------------------------------------------

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // ----------------------------------------------------------------
  // interrupt and output pin
  // ----------------------------------------------------------------
  wire irq_now  = |(flag_reg & mask_reg);
  wire flag_any = |flag_reg;
  logic pin_reg;
  logic irq_reg;

  // level interrupt, registered so it never glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_now;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_reg <= 1'b0;
    end else begin
      case (fabm_pinsel_e'(pinsel_reg))
        FABM_PIN_OFF:         pin_reg <= 1'b0;
        FABM_PIN_FLAG_ANY:    pin_reg <= flag_any;
        FABM_PIN_IRQ:         pin_reg <= irq_now | ext_sync2_reg;
        FABM_PIN_FLAG_OR_IRQ: pin_reg <= flag_any | irq_now | ext_sync2_reg;
        default:              pin_reg <= 1'b0;
      endcase
    end
  end

  assign irq                = irq_reg;
  assign general_output_pin = pin_reg;

endmodule
